// file: src/adr_register_map.sv
// How it works
// - sixteen volatile registers, sequentially accessible
// - result at 0x0, 24 or 32 bits
// - modulator mode: result is four comparator bits
// - offset and gain correction applied when enabled
// - result refreshed on every data-ready event
// - result copy latched when read command starts
// - double buffered, new data never lost
// - 0x1 mode, clock and bias selection
// - 0x2 prescaler and oversampling ratio
// - 0x3 boost, gain, auto-zero controls
// - 0x4 conversion mode, formats, correction enables
// - 0x5 interrupt flags and pin controls
// - 0x6 positive and negative input select
// - 0x7 sequencer, 0x8 sequencer delay count
// - 0x9 offset correction value
// - 0xa gain correction value
// - 0xd key governing write lock
// - 0xf checksum over setup registers
`timescale 1ns/1ps
module adr_register_map
	import adr_pkg::*;
#(
	parameter logic [1:0] DEV_ADDR = 2'h1,
	parameter logic [7:0] UNLOCK_KEY = 8'ha5,
	parameter int RESULT_BITS = 24
) (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_spi_cs_n,
	input wire logic i_spi_sck,
	input wire logic i_spi_mosi,
	output logic o_spi_miso,
	output logic o_spi_miso_oe,
	input wire logic i_conv_valid,
	input wire logic [23:0] i_conv_data,
	input wire logic i_mod_valid,
	input wire logic [3:0] i_mod_bits,
	output logic [7:0] o_setup_0,
	output logic [7:0] o_setup_1,
	output logic [7:0] o_setup_2,
	output logic [7:0] o_setup_3,
	output logic [7:0] o_irq_control,
	output logic [7:0] o_input_selector,
	output logic [23:0] o_seq_setup,
	output logic [23:0] o_seq_delay,
	output logic o_write_unlocked
);

	// the datapath is sized for a 24-bit converter only; the check is
	// made while the design is elaborated, before any clock runs
	if (RESULT_BITS != int'(ADR_W_24)) begin : g_width_check
		$error("adr_register_map supports RESULT_BITS = 24 only");
	end

	// whole state: register file, frozen result copy, engine state,
	// the sck and select samples used to find their edges, the two
	// shift registers, and the bit count and width of the register
	// now on the wire
	typedef struct packed {
		logic [ADR_NUM_REGS-1:0][31:0] mem;
		logic [31:0] shadow;
		adr_state_e_t st;
		logic sck_q;
		logic cs_q;
		logic [31:0] sh;
		logic [31:0] rx;
		logic [5:0] cnt;
		logic [5:0] width;
		logic [3:0] addr;
		logic [1:0] op;
		logic miso;
		logic miso_oe;
		logic unlocked;
	} adr_state_t;

	// q is what the flops hold, d what they take at the next edge
	adr_state_t q;
	adr_state_t d;

	// width of a register as seen on the serial link
	function automatic logic [5:0] adr_width(input logic [3:0] a,
			input logic [1:0] fmt, input logic modsel);
		logic [5:0] w;
		w = ADR_W_8;
		unique case (a)
			ADR_A_RESULT: begin
				if (modsel) begin
					w = ADR_W_MOD;
				end else if (fmt == ADR_FMT_24) begin
					w = ADR_W_24;
				end else begin
					w = ADR_W_32;
				end
			end
			ADR_A_SEQ, ADR_A_SEQDLY, ADR_A_OFFSET, ADR_A_GAIN,
			ADR_A_SPARE_B: begin
				w = ADR_W_24;
			end
			ADR_A_SPARE_E, ADR_A_CHECKSUM: begin
				w = ADR_W_16;
			end
			default: begin
				// key 0xd, spare 0xc and the setup bytes are 8 bits
				w = ADR_W_8;
			end
		endcase
		return w;
	endfunction : adr_width

	// signed offset add, then gain with 0x800000 as unity, saturated
	function automatic logic [23:0] adr_calibrate(input logic [23:0] raw,
			input logic [23:0] off, input logic [23:0] gain,
			input logic oen, input logic gen);
		logic signed [24:0] sum;
		logic signed [49:0] res;
		// one spare bit on top, so the offset sum itself cannot wrap
		sum = signed'({raw[23], raw});
		if (oen) begin
			sum = sum + signed'({off[23], off});
		end
		res = 50'(sum);
		// gain is unsigned, so it can scale but never invert the code;
		// the 50-bit product cannot overflow for any 24-bit inputs
		if (gen) begin
			res = (res * signed'(50'({1'b0, gain}))) >>> ADR_GAIN_SHIFT;
		end
		// saturation avoids a wrap from full scale to the other rail
		if (res > ADR_POS_MAX) begin
			return ADR_SAT_POS;
		end else if (res < ADR_NEG_MIN) begin
			return ADR_SAT_NEG;
		end
		return res[23:0];
	endfunction : adr_calibrate

	// 24-bit code placed in the selected output word layout
	function automatic logic [31:0] adr_format(input logic [23:0] v,
			input logic [1:0] fmt);
		if (fmt == ADR_FMT_24) begin
			return {8'h00, v};
		end else if (fmt == ADR_FMT_PAD) begin
			return {v, 8'h00};
		end
		// both remaining codes give the sign-extended word
		return {{8{v[23]}}, v};
	endfunction : adr_format

	// sum of bits 15:0 and bits 23:16 of the setup registers, 0x1 up to 0xe
	// a plain sum, not a polynomial check: it sees a flipped bit but
	// not two bytes that have swapped places
	function automatic logic [15:0] adr_checksum(
			input logic [ADR_NUM_REGS-1:0][31:0] m);
		logic [15:0] acc;
		acc = 16'h0000;
		for (int i = 1; i < ADR_NUM_REGS - 1; i++) begin
			acc = acc + m[i][15:0] + {8'h00, m[i][23:16]};
		end
		return acc;
	endfunction : adr_checksum

	// helpers of the next-state process, each given a value at its top
	logic rise;
	logic fall;
	logic [1:0] fmt;
	logic modsel;
	logic [31:0] rx;
	logic [5:0] cnt;
	logic ld_en;
	logic [3:0] ld_addr;
	logic [5:0] ld_w;
	logic [31:0] ld_val;
	logic [31:0] wmask;
	logic drdy_clr;
	logic [23:0] cal;

	// whole next state of the block in one place
	always_comb begin
		d = q;
		rise = 1'b0;
		fall = 1'b0;
		rx = q.rx;
		cnt = q.cnt;
		ld_en = 1'b0;
		ld_addr = q.addr;
		ld_w = ADR_W_8;
		ld_val = 32'h0000_0000;
		wmask = 32'h0000_0000;
		drdy_clr = 1'b0;
		fmt = q.mem[ADR_A_SETUP3][ADR_FMT_LSB+:2];
		modsel = q.mem[ADR_A_IRQ][ADR_MODSEL_BIT];
		cal = adr_calibrate(i_conv_data, q.mem[ADR_A_OFFSET][23:0],
			q.mem[ADR_A_GAIN][23:0], q.mem[ADR_A_SETUP3][ADR_OFFEN_BIT],
			q.mem[ADR_A_SETUP3][ADR_GAINEN_BIT]);
		d.sck_q = i_spi_sck;
		d.cs_q = i_spi_cs_n;

		// serial side: pins are taken as already synchronous
		if (i_spi_cs_n) begin
			// deselect ends the frame; a register cut short is dropped,
			// since a write only lands when its last bit is taken
			d.st = ADR_ST_IDLE;
			d.miso = 1'b0;
			d.miso_oe = 1'b0;
		end else if (q.cs_q) begin
			// frame start: status byte goes out while command comes in
			// an sck edge in this same cycle is not counted, so the host
			// must keep sck low around the select edge
			d.st = ADR_ST_CMD;
			d.cnt = 6'h00;
			d.rx = 32'h0000_0000;
			d.miso = q.mem[ADR_A_IRQ][7];
			d.sh = {q.mem[ADR_A_IRQ][6:0], 25'h0000000};
			d.miso_oe = 1'b1;
		end else begin
			// edges are found against the last sample, so sck must stay
			// at each level for at least one clock or an edge may be missed
			rise = i_spi_sck & ~q.sck_q;
			fall = ~i_spi_sck & q.sck_q;
			// status bits leave during the command, register bits after
			// drive on the falling edge, msb first
			if (fall && q.st != ADR_ST_IDLE) begin
				d.miso = q.sh[31];
				d.sh = {q.sh[30:0], 1'b0};
			end
			if (rise && q.st != ADR_ST_IDLE) begin
				rx = {q.rx[30:0], i_spi_mosi};
				cnt = q.cnt + 6'h01;
				d.rx = rx;
				d.cnt = cnt;
				unique case (q.st)
					ADR_ST_CMD: begin
						if (cnt == ADR_CMD_BITS) begin
							d.cnt = 6'h00;
							// foreign address or fast command: go quiet
							// miso stays released until the next select
							if (rx[7:6] != DEV_ADDR || rx[1:0] == ADR_OP_FAST) begin
								d.st = ADR_ST_IDLE;
								d.miso_oe = 1'b0;
							end else begin
								d.st = ADR_ST_XFER;
								d.op = rx[1:0];
								d.addr = rx[5:2];
								ld_en = 1'b1;
								ld_addr = rx[5:2];
							end
						end
					end
					ADR_ST_XFER: begin
						// the next register loads on the edge that takes
						// the last bit, so words follow with no gap
						if (cnt == q.width) begin
							d.cnt = 6'h00;
							if (q.op == ADR_OP_INC_WR) begin
								// bits above the width are stale shift data
								wmask = 32'((33'h1 << q.width) - 33'h1);
								if (q.addr == ADR_A_LOCK) begin
									// key register stays writable while locked
									d.mem[ADR_A_LOCK] = rx & wmask;
								end else if (q.unlocked) begin
									unique case (q.addr)
										ADR_A_RESULT, ADR_A_CHECKSUM: begin
											d.mem[q.addr] = q.mem[q.addr];
										end
										ADR_A_IRQ: begin
											// status flags belong to hardware
											d.mem[ADR_A_IRQ] =
												(q.mem[ADR_A_IRQ] & ~ADR_IRQ_WMASK)
												| (rx & ADR_IRQ_WMASK);
										end
										default: begin
											d.mem[q.addr] = rx & wmask;
										end
									endcase
								end
							end
							// static read stays put, others walk up
							if (q.op != ADR_OP_STATIC_RD) begin
								ld_addr = q.addr + 4'h1;
							end
							d.addr = ld_addr;
							ld_en = 1'b1;
						end
					end
					default: begin
						d.st = ADR_ST_IDLE;
					end
				endcase
			end
		end

		// present the next register, left aligned in the shifter
		// the checksum is summed at load time, so it already includes
		// writes made earlier in the same frame, but not a write to 0xe on the same edge
		if (ld_en) begin
			ld_w = adr_width(ld_addr, fmt, modsel);
			if (ld_addr == ADR_A_RESULT) begin
				// frozen copy; a conversion landing now goes to mem only
				d.shadow = q.mem[ADR_A_RESULT];
				ld_val = q.mem[ADR_A_RESULT];
				drdy_clr = 1'b1;
			end else if (ld_addr == ADR_A_CHECKSUM) begin
				ld_val = {16'h0000, adr_checksum(q.mem)};
			end else begin
				ld_val = q.mem[ld_addr];
			end
			d.width = ld_w;
			d.sh = ld_val << (ADR_W_32 - ld_w);
		end

		// data-ready flag: clear on read start, a new event wins
		// the clear is applied before the set in this pass, so an event
		// in the very cycle of the clear is never lost
		if (drdy_clr) begin
			d.mem[ADR_A_IRQ][ADR_DRDY_BIT] = 1'b0;
		end
		// comparator nibbles refresh the result but raise no flag
		if (modsel) begin
			if (i_mod_valid) begin
				d.mem[ADR_A_RESULT] = {28'h0000000, i_mod_bits};
			end
		end else if (i_conv_valid) begin
			d.mem[ADR_A_RESULT] = adr_format(cal, fmt);
			d.mem[ADR_A_IRQ][ADR_DRDY_BIT] = 1'b1;
		end

		// taken from the next key value, so the word after the key in
		// the same frame already sees the new lock state
		d.unlocked = (d.mem[ADR_A_LOCK][7:0] == UNLOCK_KEY);

		// synchronous reset to power-on values; it comes last so that
		// it overrides every assignment above
		if (i_sys_rst) begin
			d = '0;
			d.st = ADR_ST_IDLE;
			d.sck_q = 1'b0;
			d.cs_q = 1'b1;
			d.mem[ADR_A_SETUP0] = ADR_SETUP0_RST;
			d.mem[ADR_A_SETUP1] = ADR_SETUP1_RST;
			d.mem[ADR_A_SETUP2] = ADR_SETUP2_RST;
			d.mem[ADR_A_GAIN] = ADR_GAIN_RST;
			d.mem[ADR_A_LOCK] = {24'h000000, UNLOCK_KEY};
			d.width = ADR_W_8;
			d.unlocked = 1'b1;
		end
	end

	// single register stage for all state
	// no reset term here: reset is folded into the next state
	always_ff @(posedge i_mclk) begin
		q <= d;
	end

	// all outputs come straight from state flops
	// miso reads low once deselected; a refused command leaves the last status bit on it while released
	assign o_spi_miso = q.miso;
	assign o_spi_miso_oe = q.miso_oe;
	assign o_setup_0 = q.mem[ADR_A_SETUP0][7:0];
	assign o_setup_1 = q.mem[ADR_A_SETUP1][7:0];
	assign o_setup_2 = q.mem[ADR_A_SETUP2][7:0];
	assign o_setup_3 = q.mem[ADR_A_SETUP3][7:0];
	assign o_irq_control = q.mem[ADR_A_IRQ][7:0];
	assign o_input_selector = q.mem[ADR_A_INSEL][7:0];
	assign o_seq_setup = q.mem[ADR_A_SEQ][23:0];
	assign o_seq_delay = q.mem[ADR_A_SEQDLY][23:0];
	assign o_write_unlocked = q.unlocked;

endmodule : adr_register_map

// file: src/adr_pkg.sv
package adr_pkg;
	// register addresses
	localparam logic [3:0] ADR_A_RESULT = 4'h0;
	localparam logic [3:0] ADR_A_SETUP0 = 4'h1;
	localparam logic [3:0] ADR_A_SETUP1 = 4'h2;
	localparam logic [3:0] ADR_A_SETUP2 = 4'h3;
	localparam logic [3:0] ADR_A_SETUP3 = 4'h4;
	localparam logic [3:0] ADR_A_IRQ = 4'h5;
	localparam logic [3:0] ADR_A_INSEL = 4'h6;
	localparam logic [3:0] ADR_A_SEQ = 4'h7;
	localparam logic [3:0] ADR_A_SEQDLY = 4'h8;
	localparam logic [3:0] ADR_A_OFFSET = 4'h9;
	localparam logic [3:0] ADR_A_GAIN = 4'ha;
	localparam logic [3:0] ADR_A_SPARE_B = 4'hb;
	localparam logic [3:0] ADR_A_SPARE_C = 4'hc;
	localparam logic [3:0] ADR_A_LOCK = 4'hd;
	localparam logic [3:0] ADR_A_SPARE_E = 4'he;
	localparam logic [3:0] ADR_A_CHECKSUM = 4'hf;
	localparam int ADR_NUM_REGS = 16;
	// register widths in bits
	localparam logic [5:0] ADR_W_MOD = 6'h04;
	localparam logic [5:0] ADR_W_8 = 6'h08;
	localparam logic [5:0] ADR_W_16 = 6'h10;
	localparam logic [5:0] ADR_W_24 = 6'h18;
	localparam logic [5:0] ADR_W_32 = 6'h20;
	// reset values
	localparam logic [31:0] ADR_SETUP0_RST = 32'h0000_00c0;
	localparam logic [31:0] ADR_SETUP1_RST = 32'h0000_000c;
	localparam logic [31:0] ADR_SETUP2_RST = 32'h0000_008b;
	localparam logic [31:0] ADR_GAIN_RST = 32'h0080_0000;
	// field positions
	localparam int ADR_FMT_LSB = 4;
	localparam int ADR_OFFEN_BIT = 1;
	localparam int ADR_GAINEN_BIT = 0;
	localparam int ADR_MODSEL_BIT = 3;
	localparam int ADR_DRDY_BIT = 6;
	localparam logic [31:0] ADR_IRQ_WMASK = 32'h0000_000f;
	// output data formats
	localparam logic [1:0] ADR_FMT_24 = 2'h0;
	localparam logic [1:0] ADR_FMT_PAD = 2'h1;
	// command byte
	localparam logic [5:0] ADR_CMD_BITS = 6'h08;
	localparam logic [1:0] ADR_OP_FAST = 2'h0;
	localparam logic [1:0] ADR_OP_STATIC_RD = 2'h1;
	localparam logic [1:0] ADR_OP_INC_WR = 2'h2;
	// calibration arithmetic
	localparam int ADR_GAIN_SHIFT = 23;
	localparam logic signed [49:0] ADR_POS_MAX = 50'sh7fffff;
	localparam logic signed [49:0] ADR_NEG_MIN = -50'sh800000;
	localparam logic [23:0] ADR_SAT_POS = 24'h7fffff;
	localparam logic [23:0] ADR_SAT_NEG = 24'h800000;
	// serial engine states
	typedef enum logic [2:0] {
		ADR_ST_IDLE = 3'b001,
		ADR_ST_CMD = 3'b010,
		ADR_ST_XFER = 3'b100
	} adr_state_e_t;
endpackage : adr_pkg

// file: testbench/adr_register_map_props.sv
`timescale 1ns/1ps
module adr_register_map_props
	import adr_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_spi_cs_n,
	input wire logic i_spi_sck,
	input wire logic i_conv_valid,
	input wire logic o_spi_miso,
	input wire logic o_spi_miso_oe,
	input wire logic [7:0] o_setup_0,
	input wire logic [7:0] o_setup_3,
	input wire logic [7:0] o_irq_control,
	input wire logic o_write_unlocked
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	// reset edge itself is masked, so look at the first edge after it
	reset_vals_a: assert property (
		$fell(i_sys_rst) |-> o_setup_0 == ADR_SETUP0_RST[7:0] &&
		o_setup_3 == 8'h00 && o_irq_control == 8'h00 &&
		o_write_unlocked && !o_spi_miso_oe)
		else $error("reset values wrong");
	oe_start_a: assert property (
		$fell(i_spi_cs_n) |=> o_spi_miso_oe)
		else $error("miso not driven after select");
	frame_end_a: assert property (
		$rose(i_spi_cs_n) |=> !o_spi_miso_oe && !o_spi_miso)
		else $error("miso not released after deselect");
	idle_quiet_a: assert property (
		i_spi_cs_n [*2] |-> !o_spi_miso_oe)
		else $error("miso driven while idle");
	// a word on the wire may only move one cycle after a seen sck fall
	miso_timing_a: assert property (
		o_spi_miso_oe && !i_spi_cs_n && !$past(i_spi_cs_n) &&
		!$past(i_spi_cs_n, 2) && $changed(o_spi_miso) |->
		$past(i_spi_sck, 2) && !$past(i_spi_sck))
		else $error("miso moved without sck fall");
	locked_hold_a: assert property (
		!o_write_unlocked |=> $stable(o_setup_0) && $stable(o_setup_3))
		else $error("setup changed while locked");
	drdy_set_a: assert property (
		i_conv_valid && !o_irq_control[3] |=> o_irq_control[6])
		else $error("data ready flag not set");
	drdy_clear_a: assert property (
		$fell(o_irq_control[6]) && !$past(i_sys_rst) |->
		!$past(i_spi_cs_n))
		else $error("data ready cleared outside a frame");
	cfg_write_a: assert property (
		($changed(o_setup_0) || $changed(o_irq_control[3:0])) &&
		!$past(i_sys_rst) |-> !$past(i_spi_cs_n))
		else $error("setup changed outside a frame");
endmodule : adr_register_map_props

// file: testbench/adr_host_model.sv
`timescale 1ns/1ps
module adr_host_model (
	input wire logic i_mclk,
	input wire logic i_miso,
	output logic o_cs_n,
	output logic o_sck,
	output logic o_mosi
);
	initial begin
		o_cs_n = 1'b1;
		o_sck = 1'b0;
		o_mosi = 1'b0;
	end
	// mode 0: mosi moves while sck low, miso taken just before the rise
	task automatic bit_x(input logic b, output logic q);
		o_sck = 1'b0;
		o_mosi = b;
		repeat (2) @(negedge i_mclk);
		q = i_miso;
		o_sck = 1'b1;
		repeat (2) @(negedge i_mclk);
	endtask : bit_x
	// command byte then n data bits, msb first
	task automatic frame(input logic [7:0] c, input int n,
		input logic [63:0] w, output logic [63:0] r);
		logic q;
		r = '0;
		@(negedge i_mclk);
		o_cs_n = 1'b0;
		repeat (2) @(negedge i_mclk);
		for (int i = 7; i >= 0; i--) bit_x(c[i], q);
		for (int i = n - 1; i >= 0; i--) begin
			bit_x(w[i], q);
			r[i] = q;
		end
		o_sck = 1'b0;
		repeat (2) @(negedge i_mclk);
		o_cs_n = 1'b1;
		// mosi flips after deselect, which the idle device must ignore
		o_mosi = ~o_mosi;
		repeat (2) @(negedge i_mclk);
	endtask : frame
endmodule : adr_host_model

// file: testbench/adr_register_map_test.sv
`timescale 1ns/1ps
module adr_register_map_test;
	import adr_pkg::*;
	logic i_mclk = 1'b0, i_sys_rst = 1'b1;
	logic i_conv_valid = 1'b0, i_mod_valid = 1'b0;
	logic [23:0] i_conv_data = '0;
	logic [3:0] i_mod_bits = '0;
	logic i_spi_cs_n, i_spi_sck, i_spi_mosi, o_spi_miso, o_spi_miso_oe;
	logic [7:0] o_setup_0, o_setup_1, o_setup_2, o_setup_3;
	logic [7:0] o_irq_control, o_input_selector;
	logic [23:0] o_seq_setup, o_seq_delay;
	logic o_write_unlocked;
	logic [31:0] m [16];
	logic [63:0] r;
	int fails = 0, checked = 0;
	always #2 i_mclk = ~i_mclk;
	adr_host_model i_host (.i_mclk, .i_miso(o_spi_miso),
		.o_cs_n(i_spi_cs_n), .o_sck(i_spi_sck), .o_mosi(i_spi_mosi));
	adr_register_map i_dut (.i_mclk, .i_sys_rst, .i_spi_cs_n, .i_spi_sck,
		.i_spi_mosi, .o_spi_miso, .o_spi_miso_oe, .i_conv_valid,
		.i_conv_data, .i_mod_valid, .i_mod_bits, .o_setup_0, .o_setup_1,
		.o_setup_2, .o_setup_3, .o_irq_control, .o_input_selector,
		.o_seq_setup, .o_seq_delay, .o_write_unlocked);
	// register width as the current mode sets it
	function automatic int wd(input logic [3:0] a);
		if (a == 4'h0) return m[5][3] ? 4 : (m[4][5:4] == 2'h0 ? 24 : 32);
		if (a >= 4'h7 && a <= 4'hb) return 24;
		return a >= 4'he ? 16 : 8;
	endfunction : wd
	function automatic logic [15:0] csum();
		logic [15:0] s;
		s = '0;
		for (int i = 1; i < 15; i++) s += m[i][15:0] + m[i][23:16];
		return s;
	endfunction : csum
	task automatic cmp(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	// expectation fixed before the frame; the flag clears at the command
	task automatic rd(input logic [3:0] a);
		logic [63:0] e;
		int n;
		n = wd(a);
		e = (a == 4'hf) ? 64'(csum()) : 64'(m[a]);
		if (a == 4'h0) m[5][6] = 1'b0;
		i_host.frame({2'h1, a, 2'h3}, n, '0, r);
		cmp("read", e & ((64'h1 << n) - 1), r);
	endtask : rd
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		i_host.frame({2'h1, a, 2'h2}, wd(a), 64'(v), r);
		if (m[13][7:0] == 8'ha5 || a == 4'hd) begin
			if (a == 4'h5) m[5][3:0] = v[3:0];
			else if (a != 4'h0 && a != 4'hf) m[a] = v;
		end
	endtask : wr
	task automatic pulse(input logic md, input logic [23:0] c,
		input logic [31:0] e);
		@(negedge i_mclk);
		i_conv_valid = !md;
		i_mod_valid = md;
		i_conv_data = c;
		i_mod_bits = c[3:0];
		@(negedge i_mclk);
		i_conv_valid = 1'b0;
		i_mod_valid = 1'b0;
		m[0] = e;
		if (!md) m[5][6] = 1'b1;
		repeat (4) @(negedge i_mclk); // settle before reading
	endtask : pulse
	task automatic ports();
		cmp("setup", 64'({o_setup_0, o_setup_1, o_setup_2, o_setup_3,
			o_irq_control, o_input_selector}), 64'({m[1][7:0], m[2][7:0],
			m[3][7:0], m[4][7:0], m[5][7:0], m[6][7:0]}));
		cmp("seq", 64'({o_seq_setup, o_seq_delay, o_write_unlocked}),
			64'({m[7][23:0], m[8][23:0], 1'b1}));
	endtask : ports
	task automatic conclude();
		if (fails == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	logic [7:0] cf [4] = '{8'h02, 8'h03, 8'h10, 8'h20};
	logic [23:0] cc [4] = '{24'h7ffff0, 24'h100000, 24'h123456, 24'h800001};
	logic [31:0] ce [4] = '{32'h7fffff, 32'h080010, 32'h12345600,
		32'hff800001};
	initial begin
		m = '{default: 32'h0};
		m[1] = ADR_SETUP0_RST;
		m[2] = ADR_SETUP1_RST;
		m[3] = ADR_SETUP2_RST;
		m[10] = ADR_GAIN_RST;
		m[13] = 32'ha5;
		repeat (4) @(negedge i_mclk);
		i_sys_rst = 1'b0;
		ports();
		for (int a = 0; a < 16; a++) rd(4'(a));
		i_host.frame(8'h7b, 56, '0, r);
		cmp("wrap", 64'({m[14][15:0], csum(), m[0][23:0]}), r);
		for (int a = 1; a < 15; a++) if (a != 13) wr(4'(a),
			{8'(a), 8'hc3, 4'(a), 4'h6} & ((32'h1 << wd(4'(a))) - 1));
		ports();
		for (int a = 0; a < 16; a++) rd(4'(a));
		i_host.frame(8'h45, 16, '0, r);
		cmp("static", 64'({m[1][7:0], m[1][7:0]}), r);
		// wrong device address, then the fast opcode
		for (int k = 0; k < 2; k++) begin
			i_host.frame(k ? 8'h44 : 8'h86, 8, 64'h3c, r);
			cmp("refused", 64'(m[1][7:0]), 64'(o_setup_0));
		end
		wr(4'hd, 32'h0);
		cmp("lock", 64'h0, 64'(o_write_unlocked));
		wr(4'h1, 32'h99);
		rd(4'h1);
		wr(4'hd, 32'ha5);
		wr(4'h9, 32'h20);
		wr(4'ha, 32'h400000);
		for (int k = 0; k < 4; k++) begin
			wr(4'h4, 32'(cf[k]));
			pulse(1'b0, cc[k], ce[k]);
			rd(4'h0);
		end
		wr(4'h4, 32'h0);
		pulse(1'b0, 24'h000111, 32'h111);
		// a conversion lands while the word is on the wire
		fork
			rd(4'h0);
			begin
				repeat (45) @(negedge i_mclk);
				pulse(1'b0, 24'h000222, 32'h222);
			end
		join
		rd(4'h5);
		rd(4'h0);
		wr(4'h5, 32'h08);
		pulse(1'b1, 24'h00000a, 32'ha);
		rd(4'h0);
		conclude();
	end
	// about 7000 cycles of traffic; nearly six times that means a hang
	initial begin
		#160000;
		fails++;
		conclude();
	end
endmodule : adr_register_map_test
bind adr_register_map adr_register_map_props i_props (.i_mclk, .i_sys_rst,
	.i_spi_cs_n, .i_spi_sck, .i_conv_valid, .o_spi_miso, .o_spi_miso_oe,
	.o_setup_0, .o_setup_3, .o_irq_control, .o_write_unlocked);
